//--- hdl/obl_cfg.svh
/*
  Constants of the option byte loader: option area addresses, field
  positions, register offsets and reset values.
  Assumes inclusion by the package and by the loader module.
*/
`ifndef OBL_CFG_SVH
`define OBL_CFG_SVH

// ----------------------------------------
// option area addresses
// ----------------------------------------
`define OBL_ADDR_WDOG 8'h80
`define OBL_ADDR_RSV1 8'h81
`define OBL_ADDR_RSV3 8'h83
`define OBL_ADDR_DBG 8'h84
`define OBL_ADDR_LAST 8'h84

// ----------------------------------------
// watchdog and debug byte fields
// ----------------------------------------
`define OBL_WIN_HI 6
`define OBL_WIN_LO 5
`define OBL_WDEN_BIT 4
`define OBL_OVF_HI 3
`define OBL_OVF_LO 1
`define OBL_LOCK_BIT 0
`define OBL_DBG_HI 1
`define OBL_DBG_LO 0
`define OBL_OVF_BASE 5'h0A

// ----------------------------------------
// register port offsets and reset values
// ----------------------------------------
`define OBL_REG_WDOG 8'h80
`define OBL_REG_DBG 8'h84
`define OBL_REG_STATUS 8'h90
`define OBL_REG_OSC_MODE 8'h91
`define OBL_RST_BYTE 8'h00
`define OBL_FLASH_LAT 2'h1

`endif

//--- hdl/obl_pkg.sv
/*
  Types of the option byte loader.
  Assumes obl_cfg.svh on the include path.
*/
`include "obl_cfg.svh"

package obl_pkg;

  typedef enum logic [1:0] {
    OBL_DBG_OFF = 2'b00,
    OBL_DBG_BAD = 2'b01,
    OBL_DBG_KEEP = 2'b10,
    OBL_DBG_ERASE = 2'b11
  } obl_dbg_mode_t;

  typedef enum logic [1:0] {
    OBL_WIN_25 = 2'b00,
    OBL_WIN_50 = 2'b01,
    OBL_WIN_75 = 2'b10,
    OBL_WIN_100 = 2'b11
  } obl_window_t;

  typedef enum logic [1:0] {
    OBL_ST_ISSUE = 2'b00,
    OBL_ST_WAIT = 2'b01,
    OBL_ST_DONE = 2'b10
  } obl_state_t;

endpackage : obl_pkg

//--- hdl/obl_clk_gate.sv
/*
  Slow oscillator stop and watchdog count clock gating.
  Assumes the configuration inputs are stable once loaded.
*/
`timescale 1ns/1ps
`default_nettype none

module obl_clk_gate
  import obl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cfg_valid,
  input wire logic slow_osc_lock,
  input wire logic slow_osc_stop_request,
  input wire logic standby,
  input wire logic timer_uses_slow,
  output logic slow_osc_run,
  output logic wdog_clk_en,
  output logic timer_clk_en
);

  logic next_slow_osc_run;
  logic next_wdog_clk_en;
  logic next_timer_clk_en;

  always_comb begin
    // locked oscillator ignores the stop request
    next_slow_osc_run = slow_osc_lock | ~slow_osc_stop_request;
    // unlocked: no watchdog count clock in standby regardless of stop bit
    next_wdog_clk_en = cfg_valid & next_slow_osc_run & ~(standby & ~slow_osc_lock);
    // the timer keeps its slow clock in standby
    next_timer_clk_en = timer_uses_slow & next_slow_osc_run;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      slow_osc_run <= 1'b1;
      wdog_clk_en <= 1'b0;
      timer_clk_en <= 1'b0;
    end else begin
      slow_osc_run <= next_slow_osc_run;
      wdog_clk_en <= next_wdog_clk_en;
      timer_clk_en <= next_timer_clk_en;
    end
  end

  chk_standby_gate: assert property (@(posedge ref_clk) disable iff (rst)
    (standby && !slow_osc_lock) |=> !wdog_clk_en)
    else $error("watchdog clock ran in standby while unlocked");
  chk_lock_holds: assert property (@(posedge ref_clk) disable iff (rst)
    slow_osc_lock |=> slow_osc_run)
    else $error("locked slow oscillator stopped");
  chk_timer_standby: assert property (@(posedge ref_clk) disable iff (rst)
    (timer_uses_slow && slow_osc_lock) |=> timer_clk_en)
    else $error("timer slow clock withheld");

endmodule : obl_clk_gate

`default_nettype wire

//--- hdl/obl_loader.sv
/*
  Option byte loader: after reset reads option bytes 80h..84h from flash,
  latches watchdog, slow oscillator and debug settings, and holds them.
  Assumes a flash read port whose data stand for the addressed byte while
  the read strobe is high (taken at the edge that ends the strobe cycle),
  and a simple register port with read data one cycle after the read strobe.
*/
// The implementer's own choice: the plain strobed port.
// Functional notes
// - after every reset read the option bytes and configure before operation
// - window bits 6:5 select 25, 50 or 75 percent open period
// - enable bit 4 starts watchdog counting and illegal access detection
// - overflow bits 3:1 give 2 to the power 10 plus code slow clocks
// - lock bit 0 set makes the oscillator stop request ineffective
// - watchdog keeps counting during flash self programming
// - unlocked oscillator: no watchdog count clock in standby modes
// - timer on slow clock keeps it in standby modes
// - debug byte selects disabled, enabled keep, or enabled erase
// - debug byte bits 1:0 code the mode; 02h or 03h enables debug
`timescale 1ns/1ps
`default_nettype none
`include "obl_cfg.svh"

module obl_loader
  import obl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  // flash option area read port
  output logic flash_rd,
  output logic [7:0] flash_addr,
  input wire logic [7:0] flash_data,
  // system status
  input wire logic standby,
  input wire logic self_program,
  input wire logic timer_uses_slow,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // configuration outputs
  output logic cfg_valid,
  output logic wdog_run,
  output logic illegal_detect_en,
  output logic [1:0] open_period_sel,
  output logic [4:0] overflow_exp,
  output logic wdog_clk_en,
  output logic slow_osc_run,
  output logic timer_clk_en,
  output logic debug_en,
  output logic debug_erase_on_fail
);

  // ----------------------------------------
  // load sequencer
  // ----------------------------------------
  obl_state_t state;
  obl_state_t next_state;
  logic [7:0] addr;
  logic [7:0] next_addr;
  logic [7:0] wdog_byte;
  logic [7:0] next_wdog_byte;
  logic [7:0] dbg_byte;
  logic [7:0] next_dbg_byte;
  logic next_flash_rd;

  always_comb begin
    next_state = state;
    next_addr = addr;
    next_wdog_byte = wdog_byte;
    next_dbg_byte = dbg_byte;
    next_flash_rd = 1'b0;
    case (state)
      OBL_ST_ISSUE: begin
        next_flash_rd = 1'b1;
        next_state = OBL_ST_WAIT;
      end
      OBL_ST_WAIT: begin
        // reserved bytes are read but ignored; the programmer keeps them zero
        if (addr == `OBL_ADDR_WDOG) begin
          next_wdog_byte = flash_data;
        end else if (addr == `OBL_ADDR_DBG) begin
          next_dbg_byte = flash_data;
        end
        if (addr == `OBL_ADDR_LAST) begin
          next_state = OBL_ST_DONE;
        end else begin
          next_addr = addr + 8'h01;
          next_state = OBL_ST_ISSUE;
        end
      end
      OBL_ST_DONE: begin
        next_state = OBL_ST_DONE;
      end
      default: begin
        next_state = OBL_ST_ISSUE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= OBL_ST_ISSUE;
      addr <= `OBL_ADDR_WDOG;
      wdog_byte <= `OBL_RST_BYTE;
      dbg_byte <= `OBL_RST_BYTE;
      flash_rd <= 1'b0;
    end else begin
      state <= next_state;
      addr <= next_addr;
      wdog_byte <= next_wdog_byte;
      dbg_byte <= next_dbg_byte;
      flash_rd <= next_flash_rd;
    end
  end

  assign flash_addr = addr;

  // ----------------------------------------
  // configuration decode
  // ----------------------------------------
  logic next_cfg_valid;
  logic next_wdog_run;
  logic [1:0] next_open_period_sel;
  logic [4:0] next_overflow_exp;
  logic next_debug_en;
  logic next_debug_erase;
  logic [2:0] ovf_code;
  obl_dbg_mode_t dbg_mode;

  always_comb begin
    ovf_code = wdog_byte[`OBL_OVF_HI:`OBL_OVF_LO];
    dbg_mode = obl_dbg_mode_t'(dbg_byte[`OBL_DBG_HI:`OBL_DBG_LO]);
    next_cfg_valid = (state == OBL_ST_DONE);
    // bit 7 is ignored; the programmer keeps it zero
    next_open_period_sel = wdog_byte[`OBL_WIN_HI:`OBL_WIN_LO];
    // self programming does not pause the counter
    next_wdog_run = next_cfg_valid & wdog_byte[`OBL_WDEN_BIT];
    next_overflow_exp = `OBL_OVF_BASE + {2'b00, ovf_code};
    // the prohibited code 01 leaves debug disabled
    next_debug_en = next_cfg_valid
                    & (dbg_mode == OBL_DBG_KEEP || dbg_mode == OBL_DBG_ERASE);
    next_debug_erase = next_cfg_valid & (dbg_mode == OBL_DBG_ERASE);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_valid <= 1'b0;
      wdog_run <= 1'b0;
      illegal_detect_en <= 1'b0;
      open_period_sel <= 2'b00;
      overflow_exp <= `OBL_OVF_BASE;
      debug_en <= 1'b0;
      debug_erase_on_fail <= 1'b0;
    end else begin
      cfg_valid <= next_cfg_valid;
      wdog_run <= next_wdog_run;
      illegal_detect_en <= next_wdog_run;
      open_period_sel <= next_open_period_sel;
      overflow_exp <= next_overflow_exp;
      debug_en <= next_debug_en;
      debug_erase_on_fail <= next_debug_erase;
    end
  end

  // ----------------------------------------
  // register port
  // ----------------------------------------
  logic slow_osc_stop_request;
  logic next_stop_request;
  logic [7:0] next_rdata;

  always_comb begin
    next_stop_request = slow_osc_stop_request;
    // option bytes are read only; software writes there are dropped
    if (reg_wr && reg_addr == `OBL_REG_OSC_MODE) begin
      next_stop_request = reg_wdata[1];
    end
    next_rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr == `OBL_REG_WDOG) begin
        next_rdata = wdog_byte;
      end else if (reg_addr == `OBL_REG_DBG) begin
        next_rdata = dbg_byte;
      end else if (reg_addr == `OBL_REG_STATUS) begin
        next_rdata = {5'h00, debug_en, wdog_run, cfg_valid};
      end else if (reg_addr == `OBL_REG_OSC_MODE) begin
        next_rdata = {6'h00, slow_osc_stop_request, 1'b0};
      end else begin
        next_rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      slow_osc_stop_request <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      slow_osc_stop_request <= next_stop_request;
      reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // clock gating
  // ----------------------------------------
  obl_clk_gate u_gate (
    .ref_clk(ref_clk),
    .rst(rst),
    .cfg_valid(cfg_valid),
    .slow_osc_lock(wdog_byte[`OBL_LOCK_BIT]),
    .slow_osc_stop_request(slow_osc_stop_request),
    .standby(standby),
    .timer_uses_slow(timer_uses_slow),
    .slow_osc_run(slow_osc_run),
    .wdog_clk_en(wdog_clk_en),
    .timer_clk_en(timer_clk_en)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_load_done: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(cfg_valid) |-> $past(state) == OBL_ST_DONE)
    else $error("configuration valid before load finished");
  chk_cfg_frozen: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_valid |=> $stable(wdog_byte) && $stable(dbg_byte) && cfg_valid)
    else $error("loaded configuration changed");
  chk_wdog_enable: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_valid |=> wdog_run == $past(wdog_byte[`OBL_WDEN_BIT]))
    else $error("watchdog run does not follow enable bit");
  chk_detect_pair: assert property (@(posedge ref_clk) disable iff (rst)
    illegal_detect_en == (cfg_valid && wdog_byte[`OBL_WDEN_BIT]))
    else $error("illegal access detection differs from counting");
  chk_overflow_exp: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_valid |-> overflow_exp == 5'(10 + int'(wdog_byte[3:1])))
    else $error("overflow exponent wrong");
  chk_window_sel: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_valid |-> open_period_sel == wdog_byte[6:5])
    else $error("window select wrong");
  chk_debug_mode: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_valid |-> debug_en == dbg_byte[1] && debug_erase_on_fail == (dbg_byte[1:0] == 2'b11))
    else $error("debug mode decode wrong");
  chk_self_prog: assert property (@(posedge ref_clk) disable iff (rst)
    (wdog_run && self_program) |=> wdog_run)
    else $error("watchdog stopped during self programming");
  chk_load_time: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(rst) |-> ##[9:12] cfg_valid)
    else $error("load did not finish in time");

  cov_debug_erase: cover property (@(posedge ref_clk) $rose(debug_erase_on_fail));
  cov_wdog_on: cover property (@(posedge ref_clk) $rose(wdog_run));
  cov_osc_stop: cover property (@(posedge ref_clk) cfg_valid && !slow_osc_run);
  cov_standby: cover property (@(posedge ref_clk) cfg_valid && standby && timer_clk_en);

endmodule : obl_loader

`default_nettype wire

//--- verification/obl_flash_model.sv
/*
  Model of the flash option area: the addressed byte stands while the read
  strobe is high, with the bytes as a correct programmer leaves them.
  Assumes obl_pkg is compiled first and one clock shared with the loader.
*/
`timescale 1ns/1ps
`default_nettype none

module obl_flash_model
  import obl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic flash_rd,
  input wire logic [7:0] flash_addr,
  input wire logic [7:0] wdog_byte,
  input wire logic [1:0] dbg_code,
  output logic [7:0] flash_data
);
  logic [7:0] answer;
  logic [7:0] held = 8'h00;

  always_comb begin
    case (flash_addr)
      8'h80: answer = {1'b0, wdog_byte[6:0]};
      8'h84: answer = {6'h00, dbg_code};
      default: answer = 8'h00;
    endcase
  end

  always @(posedge ref_clk) begin
    if (flash_rd) begin
      held <= answer;
    end
  end

  // bus released outside the strobe: show a wrong value, not the last one
  assign flash_data = flash_rd ? answer : ~held;
endmodule : obl_flash_model

`default_nettype wire

//--- verification/obl_loader_tb.sv
/*
  Self-checking bench of the option byte loader with a flash model.
  Assumes the loader answers register reads one cycle after the strobe.
*/
`timescale 1ns/1ps
`default_nettype none

module obl_loader_tb
  import obl_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic flash_rd;
  logic [7:0] flash_addr;
  logic [7:0] flash_data;
  logic standby = 1'b0;
  logic self_program = 1'b0;
  logic timer_uses_slow = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic cfg_valid, wdog_run, illegal_detect_en, wdog_clk_en, slow_osc_run;
  logic timer_clk_en, debug_en, debug_erase_on_fail;
  logic [1:0] open_period_sel;
  logic [4:0] overflow_exp;
  logic [7:0] wb = 8'h00;
  logic [1:0] dbg = 2'h0;
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;
  int seed = 39793;

  always #12.5 ref_clk = ~ref_clk;

  obl_loader dut (.ref_clk(ref_clk), .rst(rst), .flash_rd(flash_rd),
    .flash_addr(flash_addr), .flash_data(flash_data), .standby(standby),
    .self_program(self_program), .timer_uses_slow(timer_uses_slow),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cfg_valid(cfg_valid), .wdog_run(wdog_run),
    .illegal_detect_en(illegal_detect_en), .open_period_sel(open_period_sel),
    .overflow_exp(overflow_exp), .wdog_clk_en(wdog_clk_en),
    .slow_osc_run(slow_osc_run), .timer_clk_en(timer_clk_en),
    .debug_en(debug_en), .debug_erase_on_fail(debug_erase_on_fail));

  obl_flash_model flash (.ref_clk(ref_clk), .flash_rd(flash_rd),
    .flash_addr(flash_addr), .wdog_byte(wb), .dbg_code(dbg),
    .flash_data(flash_data));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] exp_dbg(input logic [1:0] c);
    return {6'h00, c == 2'b11, c[1]};
  endfunction : exp_dbg

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic do_reset;
    int i;
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    #1 chk("cfg_valid_rst", 8'h00, cfg_valid);
    for (i = 0; i < 40 && cfg_valid !== 1'b1; i++) @(posedge ref_clk);
    #1 chk("cfg_valid", 8'h01, cfg_valid);
  endtask : do_reset

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      end_sim();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] d;
    logic [1:0] win;
    logic [2:0] ovf;
    logic [31:0] r;
    for (int t = 0; t < 12; t++) begin
      r = $random(seed);
      win = 2'(r[15:8] % 3);
      ovf = r[2:0];
      if (t == 0) begin
        win = 2'b10;
        ovf = 3'h7;
      end
      if (win == 2'b00 && ovf == 3'h0) ovf = 3'h1;
      @(posedge ref_clk);
      dbg <= 2'(t % 4);
      wb <= {1'b0, win, r[3], ovf, r[4]};
      self_program <= r[5];
      timer_uses_slow <= 1'b0;
      standby <= 1'b0;
      do_reset();
      chk("wdog_run", wb[4], wdog_run);
      chk("illegal_detect", wb[4], illegal_detect_en);
      chk("open_period", win, open_period_sel);
      chk("overflow_exp", 8'h0A + ovf, overflow_exp);
      chk("debug", exp_dbg(dbg), {debug_erase_on_fail, debug_en});
      reg_read(8'h84, d);
      chk("dbg_byte", {6'h00, dbg}, d);
      reg_read(8'h80, d);
      chk("wdog_byte", wb, d);
      reg_write(8'h80, ~wb);
      reg_read(8'h80, d);
      chk("wdog_byte_ro", wb, d);
      wb <= ~wb;
      reg_read(8'h90, d);
      // flash contents now differ; the status must still show the loaded enable
      chk("status", {5'h00, dbg[1], ~wb[4], 1'b1}, d);
      reg_read(8'hA5, d);
      chk("unmapped", 8'h00, d);
      chk("wdog_clk", 8'h01, wdog_clk_en);
      @(posedge ref_clk);
      wb <= ~wb;
      standby <= 1'b1;
      timer_uses_slow <= 1'b1;
      repeat (3) @(posedge ref_clk);
      #1 chk("wdog_clk_sby", wb[0], wdog_clk_en);
      chk("timer_clk_sby", 8'h01, timer_clk_en);
      @(posedge ref_clk);
      standby <= 1'b0;
      reg_write(8'h91, 8'h02);
      repeat (3) @(posedge ref_clk);
      #1 chk("osc_run", wb[0], slow_osc_run);
      chk("wdog_clk_stop", wb[0], wdog_clk_en);
      chk("timer_clk_stop", wb[0], timer_clk_en);
      reg_read(8'h91, d);
      chk("osc_mode", 8'h02, d);
      $display("test %0d done", t);
    end
    end_sim();
  end
endmodule : obl_loader_tb

`default_nettype wire
